/* hdl/fiao_info_rom.sv */
`default_nettype none
module fiao_info_rom
   import fiao_pkg::*;
#(
   parameter logic [8*PART_LEN-1:0] PART_TEXT = "PART-0000           "
) (
   // Lookup
   input wire logic [INFO_IDX_W-1:0] idx,
   output logic [DATA_W-1:0] data
);
   logic [DATA_W-1:0] mem [INFO_BYTES];
   logic [INFO_IDX_W-1:0] off;
   logic [DATA_W-1:0] ch;

   always_comb begin
      off = idx - PART_FIRST;
      ch = PART_TEXT[8*(PART_LEN-1-int'(off)) +: 8];
   end

   // ----------------------------------------
   // Area contents
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < INFO_BYTES; g++) begin : g_rom
         assign mem[g] = BLANK_BYTE;
      end
   endgenerate

   always_comb begin
      data = mem[idx];
      if (idx >= PART_FIRST &&
          idx < PART_FIRST + INFO_IDX_W'(PART_LEN)) begin
         // Spaces in the text pad as FF
         data = (ch == 8'h20) ? BLANK_BYTE : ch;
      end
   end
endmodule
`default_nettype wire

/* hdl/fiao_overlay.sv */
`default_nettype none
module fiao_overlay
   import fiao_pkg::*;
#(
   parameter int unsigned FLASH_SIZE = FLASH_BYTES,
   parameter logic [RF_ADDR_W-1:0] IMPL_MASK_BASE = 12'hF70,
   parameter logic [RF_ADDR_W-1:0] IMPL_MASK_LAST = 12'hF7F,
   parameter bit HAS_PERIPH = 1'b1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // Page select register write
   input wire logic ps_wr,
   input wire logic [DATA_W-1:0] ps_wdata,
   // Program memory request
   input wire logic pm_rd,
   input wire logic pm_wr,
   input wire logic [ADDR_W-1:0] pm_addr,
   input wire logic [DATA_W-1:0] main_rdata,
   // Data memory request
   input wire logic dm_rd,
   input wire logic dm_wr,
   // Register file probe
   input wire logic rf_rd,
   input wire logic [RF_ADDR_W-1:0] rf_addr,
   // Answers
   output logic [DATA_W-1:0] pm_rdata,
   output logic pm_rvalid,
   output logic main_wr_en,
   output logic info_en,
   output logic dm_ack,
   output logic rf_reserved
);

   // ----------------------------------------
   // Internal signals
   // ----------------------------------------
   logic [DATA_W-1:0] info_byte;
   logic in_win;
   logic beyond;
   logic overlay_hit;
   logic ps_take;
   logic rd_take;
   logic wr_take;
   logic dm_take;
   logic rf_take;
   logic next_info_en;
   logic [DATA_W-1:0] next_pm_rdata;
   logic next_pm_rvalid;
   logic next_main_wr_en;
   logic next_dm_ack;
   logic next_rf_reserved;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic logic in_window(input logic [ADDR_W-1:0] a);
      in_window = (a >= INFO_BASE) &&
         (a <= INFO_LAST);
   endfunction

   function automatic logic past_flash(input logic [ADDR_W-1:0] a);
      past_flash = 32'(a) >= FLASH_SIZE;
   endfunction

   function automatic logic absent_reg(input logic [RF_ADDR_W-1:0] a);
      absent_reg = !HAS_PERIPH &&
         (a >= CTRL_BASE) &&
         (a >= IMPL_MASK_BASE) &&
         (a <= IMPL_MASK_LAST);
   endfunction

   // ----------------------------------------
   // Information area
   // ----------------------------------------
   // Low address bits index the area
   fiao_info_rom u_rom (
      .idx(pm_addr[INFO_IDX_W-1:0]),
      .data(info_byte)
   );

   // ----------------------------------------
   // Request qualification
   // ----------------------------------------
   always_comb begin
      ps_take = clk_en && ps_wr;
      rd_take = clk_en && pm_rd;
      wr_take = clk_en && pm_wr;
      dm_take = clk_en && (dm_rd || dm_wr);
      rf_take = clk_en && rf_rd;
   end

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   always_comb begin
      in_win = in_window(pm_addr);
      beyond = past_flash(pm_addr);
      overlay_hit = info_en && in_win;
   end

   // ----------------------------------------
   // Enable bit
   // ----------------------------------------
   always_comb begin
      next_info_en = info_en;
      if (ps_take) begin
         next_info_en = ps_wdata[INFO_EN_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         info_en <= 1'b0;
      end else begin
         info_en <= next_info_en;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_comb begin
      next_pm_rdata = pm_rdata;
      if (rd_take) begin
         if (overlay_hit) begin
            next_pm_rdata = info_byte;
         end else if (beyond) begin
            next_pm_rdata = BLANK_BYTE;
         end else begin
            next_pm_rdata = main_rdata;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pm_rdata <= ZERO_BYTE;
      end else begin
         pm_rdata <= next_pm_rdata;
      end
   end

   // ----------------------------------------
   // Read valid
   // ----------------------------------------
   always_comb begin
      next_pm_rvalid = pm_rvalid;
      if (clk_en) begin
         next_pm_rvalid = rd_take;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pm_rvalid <= 1'b0;
      end else begin
         pm_rvalid <= next_pm_rvalid;
      end
   end

   // ----------------------------------------
   // Write gate
   // ----------------------------------------
   always_comb begin
      next_main_wr_en = main_wr_en;
      if (clk_en) begin
         next_main_wr_en = wr_take && !beyond && !overlay_hit;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         main_wr_en <= 1'b0;
      end else begin
         main_wr_en <= next_main_wr_en;
      end
   end

   // ----------------------------------------
   // Data space
   // ----------------------------------------
   always_comb begin
      next_dm_ack = dm_ack;
      if (clk_en) begin
         next_dm_ack = dm_take;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dm_ack <= 1'b0;
      end else begin
         dm_ack <= next_dm_ack;
      end
   end

   // ----------------------------------------
   // Reserved registers
   // ----------------------------------------
   always_comb begin
      next_rf_reserved = rf_reserved;
      if (clk_en) begin
         next_rf_reserved = rf_take && absent_reg(rf_addr);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rf_reserved <= 1'b0;
      end else begin
         rf_reserved <= next_rf_reserved;
      end
   end
endmodule
`default_nettype wire

/* hdl/fiao_pkg.sv */
`default_nettype none
package fiao_pkg;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned RF_ADDR_W = 12;
   localparam logic [ADDR_W-1:0] INFO_BASE = 16'hFE00;
   localparam logic [ADDR_W-1:0] INFO_LAST = 16'hFF7F;
   localparam int unsigned INFO_BYTES = 128;
   localparam int unsigned INFO_IDX_W = 7;
   localparam logic [INFO_IDX_W-1:0] PART_FIRST = 7'h40;
   localparam int unsigned PART_LEN = 20;
   localparam int unsigned INFO_EN_BIT = 7;
   localparam logic [DATA_W-1:0] BLANK_BYTE = 8'hFF;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam int unsigned FLASH_BYTES = 8192;
   localparam logic [RF_ADDR_W-1:0] CTRL_BASE = 12'hF00;
endpackage
`default_nettype wire

/* test/fiao_cpu_model.sv */
`default_nettype none
module fiao_cpu_model
   import fiao_pkg::*;
(
   // Main array lookup
   input wire logic [ADDR_W-1:0] pm_addr,
   output logic [DATA_W-1:0] main_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   assign main_rdata = pm_addr[7:0] ^ 8'hA5;
endmodule
`default_nettype wire

/* test/fiao_overlay_sva.sv */
`default_nettype none
module fiao_chk
   import fiao_pkg::*;
#(
   parameter int unsigned FLASH_SIZE = FLASH_BYTES,
   parameter bit HAS_PERIPH = 1'b1
) (
   // Requests and answers
   input wire logic clk_sys, rst_n, clk_en, ps_wr, pm_rd, pm_wr, dm_rd,
   input wire logic dm_wr, rf_rd, pm_rvalid, main_wr_en, info_en, dm_ack,
   input wire logic rf_reserved,
   input wire logic [DATA_W-1:0] ps_wdata, main_rdata, pm_rdata,
   input wire logic [ADDR_W-1:0] pm_addr,
   input wire logic [RF_ADDR_W-1:0] rf_addr
);
   logic w, bey;
   assign w = clk_en && pm_addr >= INFO_BASE && pm_addr <= INFO_LAST;
   assign bey = clk_en && pm_addr >= FLASH_SIZE;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_DM: assert property (clk_en && (dm_rd || dm_wr) |=> dm_ack)
      else $error("dm_ack missing");
   AST_EN: assert property (
      clk_en && ps_wr |=> info_en == $past(ps_wdata[7]))
      else $error("info_en wrong");
   AST_ON: assert property (
      pm_rd && info_en && w && pm_addr < 16'hFE40
      |=> pm_rvalid && pm_rdata == 8'hFF)
      else $error("window read wrong");
   AST_PN: assert property (
      pm_rd && info_en && w && pm_addr == 16'hFE53 |=> pm_rdata == 8'hFF)
      else $error("padding wrong");
   AST_OFF: assert property (
      clk_en && pm_rd && !info_en && pm_addr < FLASH_SIZE
      |=> pm_rdata == $past(main_rdata)) else $error("main read wrong");
   AST_BEY: assert property (
      pm_rd && bey && !(info_en && w) |=> pm_rdata == 8'hFF)
      else $error("beyond flash read wrong");
   AST_WR: assert property (
      pm_wr && (info_en && w || bey) |=> !main_wr_en)
      else $error("write not refused");
   AST_RF: assert property (
      clk_en && rf_rd && !HAS_PERIPH && rf_addr >= 12'hF70
      && rf_addr <= 12'hF7F |=> rf_reserved) else $error("not reserved");
endmodule
bind fiao_overlay fiao_chk #(.FLASH_SIZE(FLASH_SIZE),
   .HAS_PERIPH(HAS_PERIPH)) fiao_chk_i (.*);
`default_nettype wire

/* test/testbench.sv */
`default_nettype none
module testbench
   import fiao_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 0, rst_n = 0, clk_en = 1, ps_wr = 0, pm_rd = 0;
   logic pm_wr = 0, dm_rd = 0, dm_wr = 0, rf_rd = 0, main_wr_en, info_en;
   logic dm_ack, pm_rvalid, rf_reserved;
   logic [7:0] ps_wdata = 0, pm_rdata, main_rdata;
   logic [15:0] pm_addr = 0;
   logic [11:0] rf_addr = 0;
   int n_mismatch = 0, checked = 0, cyc = 0;
   always #50 clk_sys = ~clk_sys;
   fiao_overlay #(.FLASH_SIZE(65280), .HAS_PERIPH(1'b0)) fiao_overlay_i (.*);
   fiao_cpu_model fiao_cpu_model_i (.*);
   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(logic [15:0] a, logic [7:0] e);
      @(negedge clk_sys) {pm_rd, pm_addr} = {1'b1, a};
      @(negedge clk_sys) pm_rd = 0;
      chk("pm_rdata", e, pm_rdata);
      chk("pm_rvalid", 1, pm_rvalid);
   endtask
   task automatic wr(logic [15:0] a, logic e);
      @(negedge clk_sys) {pm_wr, pm_addr} = {1'b1, a};
      @(negedge clk_sys) pm_wr = 0;
      chk("main_wr_en", e, main_wr_en);
   endtask
   task automatic ps(logic [7:0] d);
      @(negedge clk_sys) {ps_wr, ps_wdata} = {1'b1, d};
      @(negedge clk_sys) ps_wr = 0;
      chk("info_en", d[7], info_en);
   endtask
   task automatic t_read();
      ps(8'h7F);
      rd(16'hFE00, 8'hA5);
      ps(8'h80);
      rd(16'hFDFF, 8'h5A);
      rd(16'hFE00, 8'hFF);
      rd(16'hFE40, 8'h50);
      rd(16'hFE53, 8'hFF);
      rd(16'hFFF0, 8'hFF);
      $display("read test done");
   endtask
   task automatic t_write();
      wr(16'hFE10, 0);
      rd(16'hFE10, 8'hFF);
      ps(8'h00);
      wr(16'hFE10, 1);
      wr(16'hFFF0, 0);
      $display("write test done");
   endtask
   task automatic t_misc();
      @(negedge clk_sys) {dm_wr, rf_rd, rf_addr} = {2'b11, 12'hF70};
      @(negedge clk_sys) {dm_wr, rf_rd} = 0;
      chk("dm_ack", 1, dm_ack);
      chk("rf_reserved", 1, rf_reserved);
      $display("misc test done");
   endtask
   task automatic t_hold();
      @(negedge clk_sys) {clk_en, ps_wr, pm_rd, ps_wdata} = {3'b011, 8'h80};
      @(negedge clk_sys) {clk_en, ps_wr, pm_rd} = 3'b100;
      chk("info_en", 0, info_en);
      chk("pm_rvalid", 0, pm_rvalid);
      $display("hold test done");
   endtask
   task automatic wrap_up();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge clk_sys);
      rst_n = 1;
      t_read();
      t_write();
      t_misc();
      t_hold();
      wrap_up();
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc > 2000) begin
         n_mismatch++;
         wrap_up();
      end
   end
endmodule
`default_nettype wire
